/* File: src/line_driver_config_pkg.sv */
// Purpose: Constants and types for the line driver configuration decoder
// Assumes: 20 MHz system clock, command bytes arrive as one-cycle strobes
// Notes: Field codes are 3 bits; code 0 of the parameter field means read
// Contract
// - Config byte: bit 7 clear, bit 0 set
// - Write: bits 6-4 parameter, 3-1 value
// - Read: parameter zero, code in 3-1
// - Response bit 0 always cleared
// - Write response echoes upper seven bits
// - Read response returns stored value bits 3-1
// - Strong pullup 16.4 to 1048 ms, 111 unlimited
// - Baud codes repeat four rates twice
// - Rising-edge shaping always enabled
// - Fall slew only at flexible, non-default code
// - Weak pullup, then active past first threshold
// - Second threshold starts on-time timer
// - Weak pullup off before pulling low
// - Standard and overdrive use default fall slew
// - Reset restores every default setting
// - Baud codes 100-111 invert receive polarity
// - Baud change response uses new rate
// - Terminate byte f1 ends unlimited pulse
package line_driver_config_pkg;
  localparam int CMD_TOP_BIT = 7;
  localparam int CMD_LSB_BIT = 0;
  localparam int PAR_HI = 6;
  localparam int PAR_LO = 4;
  localparam int VAL_HI = 3;
  localparam int VAL_LO = 1;
  localparam int RATE_INVERT_BIT = 2;
  localparam logic [2:0] PAR_READ = 3'h0;
  localparam logic [2:0] PAR_SLEW = 3'h1;
  localparam logic [2:0] PAR_PROG = 3'h2;
  localparam logic [2:0] PAR_SPU = 3'h3;
  localparam logic [2:0] PAR_WRITE_ONE_LOW_TIME = 3'h4;
  localparam logic [2:0] PAR_DSO = 3'h5;
  localparam logic [2:0] PAR_LOAD = 3'h6;
  localparam logic [2:0] PAR_RATE = 3'h7;
  localparam logic [2:0] CODE_UNLIMITED = 3'h7;
  localparam logic [2:0] RST_SLEW = 3'h0;
  localparam logic [2:0] RST_PROG = 3'h4;
  localparam logic [2:0] RST_SPU = 3'h4;
  localparam logic [2:0] RST_WRITE_ONE_LOW_TIME = 3'h0;
  localparam logic [2:0] RST_DSO = 3'h0;
  localparam logic [2:0] RST_LOAD = 3'h0;
  localparam logic [2:0] RST_RATE = 3'h0;
  localparam logic [7:0] TERMINATE_CMD = 8'hf1;
  localparam logic [4:0] WRITE_ONE_LOW_TIME_BASE_US = 5'h08;
  localparam logic [3:0] DSO_BASE_US = 4'h3;
  localparam logic [5:0] LOAD_BASE_TENTH_MA = 6'h12;
  localparam logic [5:0] LOAD_STEP_TENTH_MA = 6'h03;
  localparam logic [11:0] PROG_BASE_US = 12'h020;
  localparam int CLK_PERIOD_NS = 50;
  localparam int ACTIVE_ON_TIME_NS = 2000;
  localparam logic [5:0] ACTIVE_ON_CYCLES = 6'((ACTIVE_ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic [2:0] fall_slew_select;
    logic [2:0] prog_pulse_length;
    logic [2:0] strong_pullup_length;
    logic [2:0] write_one_low_time;
    logic [2:0] sample_offset_zero_recovery;
    logic [2:0] load_current;
    logic [2:0] serial_rate_select;
  } config_s;

  typedef struct packed {
    logic [4:0] write_one_low_us;
    logic [3:0] sample_offset_us;
    logic [5:0] load_tenth_ma;
    logic [11:0] prog_pulse_us;
    logic prog_unlimited;
    logic strong_pullup_unlimited;
    logic [1:0] rate_index;
  } decoded_s;

  localparam config_s CONFIG_RESET = '{RST_SLEW, RST_PROG, RST_SPU, RST_WRITE_ONE_LOW_TIME, RST_DSO, RST_LOAD, RST_RATE};
endpackage

/* File: src/line_driver_config_decoder.sv */
// Purpose: Configuration command decoder and edge sequencing control
// Assumes: Command bytes are one-cycle strobes from the receiver
// Notes: Bus threshold comparators and polarity pin are asynchronous
`timescale 1ns/1ps
module line_driver_config_decoder
  import line_driver_config_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic command_mode,
  input wire logic flex_speed,
  input wire logic line_polarity_pin,
  input wire logic bus_above_switch,
  input wire logic bus_above_timer,
  input wire logic drive_low_req,
  output logic resp_valid,
  output logic [7:0] resp_byte,
  output config_s cfg,
  output decoded_s decoded,
  output logic rx_invert,
  output logic fall_slew_enable,
  output logic [2:0] fall_slew_code,
  output logic pulse_terminate,
  output logic weak_pullup_current,
  output logic active_pullup_current,
  output logic pulldown_enable
);

  typedef enum logic [2:0] {EDGE_IDLE, EDGE_PREP, EDGE_LOW, EDGE_RISE_WEAK, EDGE_RISE_ACT, EDGE_HOLD} edge_e;

  function automatic logic [2:0] get_field(input config_s c, input logic [2:0] code);
    logic [2:0] v;
    v = 3'h0;
    case (code)
      PAR_SLEW: v = c.fall_slew_select;
      PAR_PROG: v = c.prog_pulse_length;
      PAR_SPU: v = c.strong_pullup_length;
      PAR_WRITE_ONE_LOW_TIME: v = c.write_one_low_time;
      PAR_DSO: v = c.sample_offset_zero_recovery;
      PAR_LOAD: v = c.load_current;
      PAR_RATE: v = c.serial_rate_select;
      default: v = 3'h0;
    endcase
    return v;
  endfunction

  function automatic config_s set_field(input config_s c, input logic [2:0] code, input logic [2:0] v);
    config_s r;
    r = c;
    case (code)
      PAR_SLEW: r.fall_slew_select = v;
      PAR_PROG: r.prog_pulse_length = v;
      PAR_SPU: r.strong_pullup_length = v;
      PAR_WRITE_ONE_LOW_TIME: r.write_one_low_time = v;
      PAR_DSO: r.sample_offset_zero_recovery = v;
      PAR_LOAD: r.load_current = v;
      PAR_RATE: r.serial_rate_select = v;
      default: r = c;
    endcase
    return r;
  endfunction

  // Synchronisers for pin inputs
  logic [2:0] pins_raw;
  logic [2:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic [2:0] filt_next;

  assign pins_raw = {line_polarity_pin, bus_above_switch, bus_above_timer};

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
      filt_reg <= 3'h0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  logic pol_q, above_switch_q, above_timer_q;
  assign pol_q = filt_reg[2];
  assign above_switch_q = filt_reg[1];
  assign above_timer_q = filt_reg[0];

  // Command decode
  logic is_config, is_read, is_write;
  logic [2:0] read_value;
  config_s cfg_reg, cfg_next;
  assign is_config = rx_valid && command_mode && !rx_byte[CMD_TOP_BIT] && rx_byte[CMD_LSB_BIT];
  assign is_read = is_config && (rx_byte[PAR_HI:PAR_LO] == PAR_READ);
  assign is_write = is_config && (rx_byte[PAR_HI:PAR_LO] != PAR_READ);
  assign read_value = get_field(cfg_reg, rx_byte[VAL_HI:VAL_LO]);

  decoded_s dec_reg, dec_next;
  logic resp_valid_reg, resp_valid_next;
  logic [7:0] resp_byte_reg, resp_byte_next;
  logic term_reg, term_next;
  logic inv_reg, inv_next;
  logic slew_en_reg, slew_en_next;
  logic [2:0] slew_code_reg, slew_code_next;

  always_comb begin
    cfg_next = cfg_reg;
    resp_valid_next = 1'b0;
    resp_byte_next = resp_byte_reg;
    term_next = rx_valid && command_mode && (rx_byte == TERMINATE_CMD);
    if (is_write) begin
      // Field stored with the response so the next waveform uses it
      cfg_next = set_field(cfg_reg, rx_byte[PAR_HI:PAR_LO], rx_byte[VAL_HI:VAL_LO]);
      resp_valid_next = 1'b1;
      resp_byte_next = {rx_byte[7:1], 1'b0};
    end else if (is_read) begin
      resp_valid_next = 1'b1;
      resp_byte_next = {rx_byte[7:4], read_value, 1'b0};
    end
    dec_next.write_one_low_us = WRITE_ONE_LOW_TIME_BASE_US + 5'(cfg_next.write_one_low_time);
    dec_next.sample_offset_us = DSO_BASE_US + 4'(cfg_next.sample_offset_zero_recovery);
    dec_next.load_tenth_ma = LOAD_BASE_TENTH_MA + 6'(LOAD_STEP_TENTH_MA * 6'(cfg_next.load_current));
    dec_next.prog_unlimited = cfg_next.prog_pulse_length == CODE_UNLIMITED;
    dec_next.prog_pulse_us = dec_next.prog_unlimited ? 12'h000 : 12'(PROG_BASE_US << cfg_next.prog_pulse_length);
    dec_next.strong_pullup_unlimited = cfg_next.strong_pullup_length == CODE_UNLIMITED;
    dec_next.rate_index = cfg_next.serial_rate_select[1:0];
    inv_next = pol_q ^ cfg_next.serial_rate_select[RATE_INVERT_BIT];
    slew_en_next = flex_speed && (cfg_next.fall_slew_select != RST_SLEW);
    slew_code_next = slew_en_next ? cfg_next.fall_slew_select : RST_SLEW;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= CONFIG_RESET;
      dec_reg <= '0;
      resp_valid_reg <= 1'b0;
      resp_byte_reg <= 8'h00;
      term_reg <= 1'b0;
      inv_reg <= 1'b0;
      slew_en_reg <= 1'b0;
      slew_code_reg <= RST_SLEW;
    end else begin
      cfg_reg <= cfg_next;
      dec_reg <= dec_next;
      resp_valid_reg <= resp_valid_next;
      resp_byte_reg <= resp_byte_next;
      term_reg <= term_next;
      inv_reg <= inv_next;
      slew_en_reg <= slew_en_next;
      slew_code_reg <= slew_code_next;
    end
  end

  // Edge sequencing; rising shaping has no disable path
  edge_e edge_reg, edge_next;
  logic [5:0] hold_reg, hold_next;
  logic weak_reg, weak_next, act_reg, act_next, pd_reg, pd_next;

  always_comb begin
    edge_next = edge_reg;
    hold_next = hold_reg;
    case (edge_reg)
      EDGE_IDLE: begin
        if (drive_low_req) begin
          edge_next = EDGE_PREP;
        end else if (!above_switch_q) begin
          edge_next = EDGE_RISE_WEAK;
        end
      end
      EDGE_PREP: edge_next = EDGE_LOW;
      EDGE_LOW: begin
        if (!drive_low_req) begin
          edge_next = EDGE_RISE_WEAK;
        end
      end
      EDGE_RISE_WEAK: begin
        if (drive_low_req) begin
          edge_next = EDGE_PREP;
        end else if (above_switch_q) begin
          edge_next = EDGE_RISE_ACT;
        end
      end
      EDGE_RISE_ACT: begin
        if (drive_low_req) begin
          edge_next = EDGE_PREP;
        end else if (above_timer_q) begin
          edge_next = EDGE_HOLD;
          hold_next = ACTIVE_ON_CYCLES - 6'h01;
        end
      end
      EDGE_HOLD: begin
        if (drive_low_req) begin
          edge_next = EDGE_PREP;
        end else if (hold_reg == 6'h00) begin
          edge_next = EDGE_IDLE;
        end else begin
          hold_next = hold_reg - 6'h01;
        end
      end
      default: edge_next = EDGE_IDLE;
    endcase
    weak_next = (edge_next == EDGE_IDLE) || (edge_next == EDGE_RISE_WEAK);
    act_next = (edge_next == EDGE_RISE_ACT) || (edge_next == EDGE_HOLD);
    pd_next = edge_next == EDGE_LOW;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      edge_reg <= EDGE_IDLE;
      hold_reg <= 6'h00;
      weak_reg <= 1'b1;
      act_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else begin
      edge_reg <= edge_next;
      hold_reg <= hold_next;
      weak_reg <= weak_next;
      act_reg <= act_next;
      pd_reg <= pd_next;
    end
  end

  assign resp_valid = resp_valid_reg;
  assign resp_byte = resp_byte_reg;
  assign cfg = cfg_reg;
  assign decoded = dec_reg;
  assign rx_invert = inv_reg;
  assign fall_slew_enable = slew_en_reg;
  assign fall_slew_code = slew_code_reg;
  assign pulse_terminate = term_reg;
  assign weak_pullup_current = weak_reg;
  assign active_pullup_current = act_reg;
  assign pulldown_enable = pd_reg;

  // Cycles spent in the on-time hold, read by the on-time check
  logic [5:0] on_cnt_reg, on_cnt_next;

  always_comb begin
    on_cnt_next = (edge_reg == EDGE_HOLD) ? on_cnt_reg + 6'h01 : 6'h00;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      on_cnt_reg <= 6'h00;
    end else begin
      on_cnt_reg <= on_cnt_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  resp_lsb_clear_a: assert property (resp_valid |-> !resp_byte[0])
    else $error("Response bit 0 set");
  non_config_a: assert property (rx_valid && !is_config |=> !resp_valid)
    else $error("Response to non config byte");
  write_echo_a: assert property (is_write |=> resp_valid && resp_byte[7:1] == $past(rx_byte[7:1]))
    else $error("Write response not an echo");
  write_store_a: assert property (is_write |=> get_field(cfg, $past(rx_byte[6:4])) == $past(rx_byte[3:1]))
    else $error("Written value not stored");
  read_value_a: assert property (is_read |=> resp_valid && resp_byte[3:1] == $past(read_value) && $stable(cfg))
    else $error("Read response wrong");
  rate_change_a: assert property (is_write && rx_byte[6:4] == PAR_RATE |=> decoded.rate_index == $past(rx_byte[2:1]))
    else $error("Rate not applied with response");
  slew_gate_a: assert property ((!flex_speed)[*2] |-> !fall_slew_enable && fall_slew_code == RST_SLEW)
    else $error("Fall slew active off flexible speed");
  weak_before_low_a: assert property ($rose(pulldown_enable) |-> !weak_pullup_current && $past(!weak_pullup_current))
    else $error("Weak pullup on at pulldown start");
  rise_weak_only_a: assert property (edge_reg == EDGE_RISE_WEAK |-> weak_pullup_current && !active_pullup_current)
    else $error("Active pullup before threshold");
  hold_active_a: assert property (edge_reg == EDGE_RISE_ACT && above_timer_q && !drive_low_req |=>
    active_pullup_current[*8])
    else $error("Active pullup dropped early");
  terminate_a: assert property (rx_valid && command_mode && rx_byte == 8'hf1 |=> pulse_terminate)
    else $error("Terminate not flagged");
  slew_on_a: assert property (fall_slew_enable == ($past(flex_speed) && cfg.fall_slew_select != RST_SLEW))
    else $error("Fall slew enable wrong");
  slew_code_a: assert property (fall_slew_code == (fall_slew_enable ? cfg.fall_slew_select : RST_SLEW))
    else $error("Fall slew code wrong");
  low_no_pullup_a: assert property (pulldown_enable |-> !weak_pullup_current && !active_pullup_current)
    else $error("Pullup on while pulling low");
  pullup_excl_a: assert property (!(weak_pullup_current && active_pullup_current))
    else $error("Weak and active pullup both on");
  mode_refuse_a: assert property (rx_valid && !command_mode |=>
    !resp_valid && !pulse_terminate && $stable(cfg))
    else $error("Byte taken outside command mode");
  on_time_a: assert property (edge_reg == EDGE_HOLD ##1 edge_reg == EDGE_IDLE |->
    on_cnt_reg == ACTIVE_ON_CYCLES)
    else $error("Active pullup on-time wrong");

  read_cmd_c: cover property (is_read ##1 resp_valid);
  write_cmd_c: cover property (is_write ##1 resp_valid);
  hold_done_c: cover property (edge_reg == EDGE_HOLD ##1 edge_reg == EDGE_IDLE);
  terminate_c: cover property (pulse_terminate);
  slew_on_c: cover property (fall_slew_enable ##1 !fall_slew_enable);

endmodule

/* File: bench/host_uart_model.sv */
// Purpose: Host serial side that issues configuration bytes
// Assumes: Bytes driven 5 ns after the clock edge; next holds the strobe high for a second byte
// Notes: Released byte lines show the inverse of the last byte
`timescale 1ns/1ps
module host_uart_model
  import line_driver_config_pkg::*;
(
  input wire logic clk_sys,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  // Tuning start point kept for reload after reset
  logic [2:0] saved_slew = 3'h4;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic lead(input logic [7:0] b);
    @(posedge clk_sys);
    #5;
    rx_valid = 1'b1;
    rx_byte = b;
  endtask
  task automatic next(input logic [7:0] b);
    @(posedge clk_sys);
    #5;
    rx_byte = b;
  endtask
  task automatic drop();
    @(posedge clk_sys);
    #5;
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
  task automatic send(input logic [7:0] b);
    if (b[7:4] == 4'h3 && b[3:1] == 3'h6) begin
      return;
    end
    lead(b);
    drop();
  endtask
  task automatic reload_slew();
    send({1'b0, PAR_SLEW, saved_slew, 1'b1});
  endtask
endmodule

/* File: bench/line_driver_config_decoder_tb.sv */
// Purpose: Self-checking bench for the configuration decoder
// Assumes: Inputs change 5 ns after the rising edge
// Notes: Table rows hold command bytes and expected responses
`timescale 1ns/1ps
module line_driver_config_decoder_tb;
  import line_driver_config_pkg::*;
  // Columns: command mode, flexible speed, response expected, byte in, response byte
  typedef struct packed {logic mode; logic flex; logic ok; logic [7:0] cmd; logic [7:0] resp;} row_s;
  logic clk_sys, reset_n, rx_valid, command_mode, flex_speed, line_polarity_pin;
  logic bus_above_switch, bus_above_timer, drive_low_req, resp_valid, rx_invert;
  logic fall_slew_enable, pulse_terminate, weak_pullup_current, active_pullup_current, pulldown_enable;
  logic [7:0] rx_byte, resp_byte;
  logic [2:0] fall_slew_code;
  config_s cfg;
  decoded_s decoded;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  row_s rows [16] = '{'{1'b1, 1'b1, 1'b1, 8'h17, 8'h16}, '{1'b0, 1'b1, 1'b0, 8'h19, 8'h16},
    '{1'b1, 1'b1, 1'b1, 8'h03, 8'h06}, '{1'b1, 1'b0, 1'b1, 8'h2d, 8'h2c}, '{1'b1, 1'b0, 1'b1, 8'h05, 8'h0c},
    '{1'b1, 1'b1, 1'b1, 8'h3b, 8'h3a}, '{1'b1, 1'b1, 1'b1, 8'h07, 8'h0a}, '{1'b1, 1'b1, 1'b1, 8'h4f, 8'h4e},
    '{1'b1, 1'b1, 1'b1, 8'h09, 8'h0e}, '{1'b1, 1'b1, 1'b1, 8'h53, 8'h52}, '{1'b1, 1'b1, 1'b1, 8'h0b, 8'h02},
    '{1'b1, 1'b1, 1'b1, 8'h69, 8'h68}, '{1'b1, 1'b1, 1'b1, 8'h0d, 8'h08}, '{1'b1, 1'b1, 1'b1, 8'h75, 8'h74},
    '{1'b1, 1'b1, 1'b1, 8'h0f, 8'h04}, '{1'b1, 1'b1, 1'b1, 8'h01, 8'h00}};

  host_uart_model host(.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte));
  line_driver_config_decoder dut(.clk_sys(clk_sys), .reset_n(reset_n), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .command_mode(command_mode), .flex_speed(flex_speed),
    .line_polarity_pin(line_polarity_pin), .bus_above_switch(bus_above_switch),
    .bus_above_timer(bus_above_timer), .drive_low_req(drive_low_req), .resp_valid(resp_valid),
    .resp_byte(resp_byte), .cfg(cfg), .decoded(decoded), .rx_invert(rx_invert),
    .fall_slew_enable(fall_slew_enable), .fall_slew_code(fall_slew_code),
    .pulse_terminate(pulse_terminate), .weak_pullup_current(weak_pullup_current),
    .active_pullup_current(active_pullup_current), .pulldown_enable(pulldown_enable));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic resp_chk(input logic ok, input logic [7:0] exp);
    chk("resp_valid", {31'h0, ok}, {31'h0, resp_valid});
    chk("resp_byte", {24'h0, exp}, {24'h0, resp_byte});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    reset_n = 1'b0;
    command_mode = 1'b1;
    flex_speed = 1'b1;
    line_polarity_pin = 1'b0;
    bus_above_switch = 1'b1;
    bus_above_timer = 1'b1;
    drive_low_req = 1'b0;
    cyc(16);
    chk("cfg", 32'(CONFIG_RESET), 32'(cfg));
    reset_n = 1'b1;
    cyc(1);
    chk("write_one_low_time_us", 32'h8, 32'(decoded.write_one_low_us));
    chk("dso_us", 32'h3, 32'(decoded.sample_offset_us));
    chk("load", 32'h12, 32'(decoded.load_tenth_ma));
    chk("prog_us", 32'h200, 32'(decoded.prog_pulse_us));
    cyc(60);
    done("reset");
    foreach (rows[i]) begin
      command_mode = rows[i].mode;
      flex_speed = rows[i].flex;
      host.send(rows[i].cmd);
      resp_chk(rows[i].ok, rows[i].resp);
    end
    chk("write_one_low_time_us", 32'hf, 32'(decoded.write_one_low_us));
    chk("dso_us", 32'h4, 32'(decoded.sample_offset_us));
    chk("load", 32'h1e, 32'(decoded.load_tenth_ma));
    chk("prog_us", 32'h800, 32'(decoded.prog_pulse_us));
    chk("rate", 32'h2, 32'(decoded.rate_index));
    chk("slew_code", 32'h3, 32'(fall_slew_code));
    done("table");
    host.send(8'h97);
    chk("resp_valid", 32'h0, 32'(resp_valid));
    host.send(8'h16);
    chk("resp_valid", 32'h0, 32'(resp_valid));
    command_mode = 1'b0;
    host.send(8'h19);
    chk("resp_valid", 32'h0, 32'(resp_valid));
    host.send(TERMINATE_CMD);
    chk("terminate", 32'h0, 32'(pulse_terminate));
    command_mode = 1'b1;
    chk("slew", 32'h3, 32'(cfg.fall_slew_select));
    host.send(TERMINATE_CMD);
    chk("terminate", 32'h1, 32'(pulse_terminate));
    cyc(1);
    chk("terminate", 32'h0, 32'(pulse_terminate));
    done("refusals");
    host.lead(8'h2f);
    host.next(8'h3f);
    resp_chk(1'b1, 8'h2e);
    host.drop();
    resp_chk(1'b1, 8'h3e);
    chk("prog_unl", 32'h1, 32'(decoded.prog_unlimited));
    chk("prog_us", 32'h0, 32'(decoded.prog_pulse_us));
    chk("spu_unl", 32'h1, 32'(decoded.strong_pullup_unlimited));
    host.send(8'h79);
    resp_chk(1'b1, 8'h78);
    chk("rx_invert", 32'h1, 32'(rx_invert));
    chk("rate", 32'h0, 32'(decoded.rate_index));
    line_polarity_pin = ~line_polarity_pin;
    cyc(6);
    chk("rx_invert", 32'h0, 32'(rx_invert));
    host.send(8'h71);
    chk("rx_invert", 32'h1, 32'(rx_invert));
    done("pair_rate");
    flex_speed = 1'b0;
    cyc(2);
    chk("slew_en", 32'h0, 32'(fall_slew_enable));
    chk("slew_code", 32'h0, 32'(fall_slew_code));
    flex_speed = 1'b1;
    host.send(8'h11);
    cyc(1);
    chk("slew_en", 32'h0, 32'(fall_slew_enable));
    done("slew");
    drive_low_req = 1'b1;
    bus_above_switch = 1'b0;
    bus_above_timer = 1'b0;
    cyc(1);
    chk("weak", 32'h0, 32'(weak_pullup_current));
    chk("pulldown", 32'h0, 32'(pulldown_enable));
    cyc(1);
    chk("pulldown", 32'h1, 32'(pulldown_enable));
    cyc(3);
    drive_low_req = 1'b0;
    cyc(1);
    chk("pulldown", 32'h0, 32'(pulldown_enable));
    cyc(5);
    chk("weak", 32'h1, 32'(weak_pullup_current));
    chk("active", 32'h0, 32'(active_pullup_current));
    bus_above_switch = 1'b1;
    cyc(6);
    chk("active", 32'h1, 32'(active_pullup_current));
    chk("weak", 32'h0, 32'(weak_pullup_current));
    bus_above_timer = bus_above_switch;
    cyc(15);
    chk("active", 32'h1, 32'(active_pullup_current));
    // Last cycle of the on-time, then the switch back to weak
    cyc(29);
    chk("active", 32'h1, 32'(active_pullup_current));
    cyc(1);
    chk("active", 32'h0, 32'(active_pullup_current));
    chk("weak", 32'h1, 32'(weak_pullup_current));
    done("edges");
    reset_n = 1'b0;
    cyc(2);
    chk("cfg", 32'(CONFIG_RESET), 32'(cfg));
    reset_n = 1'b1;
    cyc(2);
    host.reload_slew();
    chk("slew", 32'h4, 32'(cfg.fall_slew_select));
    chk("slew_en", 32'h1, 32'(fall_slew_enable));
    done("second_reset");
    complete_run();
  end
endmodule
